//--- sim/core_ctrl_model.sv
// Core-side model driving the chain and phase step inputs
`timescale 1ns/1ps
`default_nettype none
module core_ctrl_model
    import pll_reconfig_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Chain controls
    output logic scan_enable_out,
    output logic scan_data_out,
    output logic config_update_out,
    input wire logic reconfig_done_in,
    // Phase step controls
    output logic phase_step_out,
    output logic phase_up_out,
    output logic [2:0] phase_select_out,
    input wire logic phase_done_in
);
    initial begin
        scan_enable_out = 1'b0;
        scan_data_out = 1'b0;
        config_update_out = 1'b0;
        phase_step_out = 1'b0;
        phase_up_out = 1'b0;
        phase_select_out = 3'h7;
    end

    // ==========================================================
    // Chain load, first bit first, then one update pulse
    task automatic load_chain(input logic [CHAIN_LEN-1:0] bits, output int busy);
        busy = 0;
        scan_enable_out = 1'b1;
        for (int i = 0; i < CHAIN_LEN; i++) begin
            scan_data_out = bits[i];
            @(negedge clk_in);
        end
        scan_enable_out = 1'b0;
        scan_data_out = ~bits[CHAIN_LEN-1];
        config_update_out = 1'b1;
        @(negedge clk_in);
        config_update_out = 1'b0;
        while (reconfig_done_in === 1'b1 && busy < 20) begin
            busy++;
            @(negedge clk_in);
        end
    endtask

    // ==========================================================
    // One phase step request held for a number of cycles
    task automatic step_phase(input logic up, input logic [2:0] sel, input int hold,
                              output int first_low, output int low_cnt, output int rises);
        logic prev;
        first_low = 0;
        low_cnt = 0;
        rises = 0;
        prev = 1'b1;
        phase_up_out = up;
        phase_select_out = sel;
        @(negedge clk_in);
        phase_step_out <= 1'b1;
        for (int k = 1; k <= hold + 12; k++) begin
            @(negedge clk_in);
            if (k == hold) begin
                phase_step_out <= 1'b0;
            end
            if (phase_done_in !== 1'b1) begin
                low_cnt++;
                if (first_low == 0) begin
                    first_low = k;
                end
            end
            if (prev === 1'b0 && phase_done_in === 1'b1) begin
                rises++;
            end
            prev = phase_done_in;
        end
    endtask
endmodule
`default_nettype wire

//--- sim/pll_reconfig_phase_shift_bench.sv
// Testbench for PLL reconfiguration and phase stepping
`timescale 1ns/1ps
`default_nettype none
module pll_reconfig_phase_shift_bench
    import pll_reconfig_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scan_enable, scan_data, config_update, reconfig_done;
    logic phase_step, phase_up, phase_done, legal, clocks_run;
    logic [2:0] phase_select;
    logic [NUM_COUNTERS-1:0][FACTOR_WIDTH-1:0] factor;
    logic [NUM_COUNTERS-1:0] bypass;
    logic [NUM_COUNTERS-1:0] odd;
    logic [NUM_COUNTERS-1:0][COUNT_WIDTH-1:0] high;
    logic [PUMP_WIDTH-1:0] pump;
    logic [RES_WIDTH-1:0] res;
    logic [CAP_WIDTH-1:0] cap;
    logic [NUM_TAPS-1:0][TAP_WIDTH-1:0] taps;
    logic [TAP_WIDTH-1:0] exp_tap [NUM_TAPS];
    int err_count = 0;
    int cmp_count = 0;

    always #5 clk_in = ~clk_in;

    pll_reconfig_phase_shift dut (.clk_in(clk_in), .rst_in(rst_in),
        .scan_enable_in(scan_enable), .scan_data_in(scan_data),
        .config_update_in(config_update), .reconfig_done_out(reconfig_done),
        .phase_step_in(phase_step), .phase_up_in(phase_up),
        .phase_select_in(phase_select), .phase_done_out(phase_done),
        .division_factor_out(factor), .counter_bypass_out(bypass), .odd_duty_out(odd),
        .high_count_out(high), .pump_current_code_out(pump),
        .filter_resistor_code_out(res), .filter_capacitor_code_out(cap),
        .settings_legal_out(legal), .phase_tap_out(taps), .output_clocks_run_out(clocks_run));

    core_ctrl_model core (.clk_in(clk_in), .scan_enable_out(scan_enable),
        .scan_data_out(scan_data), .config_update_out(config_update),
        .reconfig_done_in(reconfig_done), .phase_step_out(phase_step),
        .phase_up_out(phase_up), .phase_select_out(phase_select), .phase_done_in(phase_done));

    // ==========================================================
    // Compare and report
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset;
        check("reconfig done idle", reconfig_done, 0);
        check("phase done idle", phase_done, 1);
        check("clocks run", clocks_run, 1);
        for (int t = 0; t < NUM_TAPS; t++) begin
            exp_tap[t] = TAP_RESET;
            check("tap reset", taps[t], TAP_RESET);
        end
        $display("test reset done");
    endtask

    task automatic test_chain(input logic [6:0] byp, input logic [2:0] pc, input logic [4:0] rc,
                              input logic [1:0] cc, input logic ok);
        logic [CHAIN_LEN-1:0] v;
        logic [7:0] hi;
        logic [7:0] lo;
        int busy;
        v = '0;
        for (int k = 0; k < NUM_COUNTERS; k++) begin
            v[k*SEG_LEN+SEG_LOW_POS +: COUNT_WIDTH] = 8'h21 + 8'(k);
            v[k*SEG_LEN+SEG_HIGH_POS +: COUNT_WIDTH] = 8'h10 + 8'(k);
            v[k*SEG_LEN+SEG_ODD_POS] = 1'b1;
            v[k*SEG_LEN+SEG_BYPASS_POS] = byp[k];
        end
        v[PUMP_LSB +: PUMP_WIDTH] = pc;
        v[RES_LSB +: RES_WIDTH] = rc;
        v[CAP_LSB +: CAP_WIDTH] = cc;
        core.load_chain(v, busy);
        check("reconfig busy cycles", busy, RECONFIG_BUSY_CYCLES);
        @(negedge clk_in);
        for (int k = 0; k < NUM_COUNTERS; k++) begin
            hi = 8'h10 + 8'(k);
            lo = 8'h21 + 8'(k);
            check("factor", factor[k], byp[k] ? FACTOR_ONE : {1'b0, hi} + {1'b0, lo});
            check("bypass", bypass[k], byp[k]);
            check("odd duty", odd[k], !byp[k]);
            if (!byp[k]) begin
                check("high count", high[k], hi);
            end
        end
        check("pump code", pump, pc);
        check("resistor code", res, rc);
        check("capacitor code", cap, cc);
        check("settings legal", legal, ok);
        $display("test chain done");
    endtask

    task automatic step_and_check(input logic up, input logic [2:0] sel, input int hold);
        int first_low;
        int low_cnt;
        int rises;
        core.step_phase(up, sel, hold, first_low, low_cnt, rises);
        for (int t = 0; t < NUM_TAPS; t++) begin
            if ((sel == 3'h0 && t > 0) || (sel == 3'h1 && t == 0) || (sel == 3'(t + 1))) begin
                exp_tap[t] = up ? exp_tap[t] + TAP_STEP : exp_tap[t] - TAP_STEP;
            end
            check("tap", taps[t], exp_tap[t]);
        end
        check("done first low", first_low, 3);
        check("done low cycles", low_cnt, PHASE_BUSY_CYCLES);
        check("steps per pulse", rises, 1);
        check("clocks run", clocks_run, 1);
    endtask

    task automatic test_phase_all;
        for (int s = 0; s < 8; s++) begin
            step_and_check(s[0], 3'(s), 2);
        end
        $display("test phase select done");
    endtask

    task automatic test_long_hold;
        step_and_check(1'b1, 3'h3, 8);
        step_and_check(1'b0, 3'h1, 3);
        step_and_check(1'b1, 3'h0, 4);
        $display("test long hold done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (6) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        test_reset();
        test_chain(7'h24, 3'h6, 5'h1e, 2'h3, 1'b1);
        test_chain(7'h41, 3'h1, 5'h13, 2'h1, 1'b0);
        test_chain(7'h00, 3'h7, 5'h05, 2'h0, 1'b0);
        test_chain(7'h7f, 3'h0, 5'h1b, 2'h2, 1'b0);
        test_chain(7'h00, 3'h4, 5'h0b, 2'h1, 1'b0);
        test_chain(7'h00, 3'h4, 5'h0c, 2'h1, 1'b0);
        test_phase_all();
        test_long_hold();
        results();
    end

    initial begin
        #100000;
        err_count++;
        results();
    end
endmodule
`default_nettype wire

//--- verilog/phase_step_engine.sv
// Dynamic phase step sequencer
`timescale 1ns/1ps
`default_nettype none
module phase_step_engine
    import pll_reconfig_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Step handshake
    phase_step_if.engine ps
);

    logic step_neg_reg;
    logic step_prev_reg;
    phase_state_type state_reg;
    logic [BUSY_CNT_WIDTH-1:0] busy_reg;

    // ==========================================================
    // Falling edge sample of the request
    always_ff @(negedge clk_in) begin
        if (rst_in) begin
            step_neg_reg <= 1'b0;
        end else begin
            step_neg_reg <= ps.step_req;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            step_prev_reg <= 1'b0;
        end else begin
            step_prev_reg <= step_neg_reg;
        end
    end

    // ==========================================================
    // Sequence
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= PH_IDLE;
            busy_reg <= '0;
            ps.start <= 1'b0;
            ps.start_up <= 1'b0;
            ps.start_sel <= SEL_ALL_OUT;
            ps.done <= 1'b1;
        end else begin
            ps.start <= 1'b0;
            unique case (state_reg)
                PH_IDLE: begin
                    if (step_neg_reg && !step_prev_reg) begin
                        state_reg <= PH_ARMED;
                    end
                end
                PH_ARMED: begin
                    ps.start <= 1'b1;
                    ps.start_up <= ps.step_up;
                    ps.start_sel <= ps.step_sel;
                    ps.done <= 1'b0;
                    busy_reg <= '0;
                    state_reg <= PH_SHIFT;
                end
                PH_SHIFT: begin
                    if (busy_reg == BUSY_CNT_WIDTH'(PHASE_BUSY_CYCLES - 1)) begin
                        ps.done <= 1'b1;
                        state_reg <= PH_IDLE;
                    end else begin
                        busy_reg <= busy_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= PH_IDLE;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

//--- verilog/phase_step_if.sv
// Step request and start signals between the core and the step engine
`timescale 1ns/1ps
`default_nettype none
interface phase_step_if;
    logic step_req;
    logic step_up;
    logic [2:0] step_sel;
    logic start;
    logic start_up;
    logic [2:0] start_sel;
    logic done;
    modport engine (input step_req, input step_up, input step_sel,
                    output start, output start_up, output start_sel, output done);
    modport core (output step_req, output step_up, output step_sel,
                  input start, input start_up, input start_sel, input done);
endinterface
`default_nettype wire

//--- verilog/pll_reconfig_phase_shift.sv
// PLL reconfiguration decode and dynamic phase shift control
`timescale 1ns/1ps
`default_nettype none
module pll_reconfig_phase_shift
    import pll_reconfig_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial chain
    input wire logic scan_enable_in,
    input wire logic scan_data_in,
    input wire logic config_update_in,
    output logic reconfig_done_out,
    // Dynamic phase step
    input wire logic phase_step_in,
    input wire logic phase_up_in,
    input wire logic [2:0] phase_select_in,
    output logic phase_done_out,
    // Decoded settings
    output logic [NUM_COUNTERS-1:0][FACTOR_WIDTH-1:0] division_factor_out,
    output logic [NUM_COUNTERS-1:0] counter_bypass_out,
    output logic [NUM_COUNTERS-1:0] odd_duty_out,
    output logic [NUM_COUNTERS-1:0][COUNT_WIDTH-1:0] high_count_out,
    output logic [PUMP_WIDTH-1:0] pump_current_code_out,
    output logic [RES_WIDTH-1:0] filter_resistor_code_out,
    output logic [CAP_WIDTH-1:0] filter_capacitor_code_out,
    output logic settings_legal_out,
    // Phase taps and clock state
    output logic [NUM_TAPS-1:0][TAP_WIDTH-1:0] phase_tap_out,
    output logic output_clocks_run_out
);

    logic [CHAIN_LEN-1:0] applied;
    logic [NUM_TAPS-1:0][TAP_WIDTH-1:0] tap_reg;
    phase_step_if ps ();

    // ==========================================================
    // Field helpers
    function automatic logic [SEG_LEN-1:0] segment(input logic [CHAIN_LEN-1:0] chain,
                                                   input int idx);
        segment = chain[idx*SEG_LEN +: SEG_LEN];
    endfunction

    function automatic logic [FACTOR_WIDTH-1:0] factor(input logic [SEG_LEN-1:0] seg);
        if (seg[SEG_BYPASS_POS]) begin
            factor = FACTOR_ONE;
        end else begin
            factor = FACTOR_WIDTH'(seg[SEG_HIGH_POS +: COUNT_WIDTH])
                   + FACTOR_WIDTH'(seg[SEG_LOW_POS +: COUNT_WIDTH]);
        end
    endfunction

    function automatic logic legal_pump(input logic [PUMP_WIDTH-1:0] c);
        legal_pump = (c == 3'h0) || (c == 3'h4) || (c == 3'h6) || (c == 3'h7);
    endfunction

    function automatic logic legal_res(input logic [RES_WIDTH-1:0] c);
        legal_res = (c[1:0] == 2'h0 && c[2] == 1'b0)
                 || (c[4:3] != 2'h1 && c[2:0] == 3'h3)
                 || (c[4:3] != 2'h1 && c[2:0] == 3'h4)
                 || (c == 5'h1e);
    endfunction

    function automatic logic legal_cap(input logic [CAP_WIDTH-1:0] c);
        legal_cap = (c != 2'h2);
    endfunction

    function automatic logic [TAP_WIDTH-1:0] step_tap(input logic [TAP_WIDTH-1:0] t,
                                                      input logic up);
        step_tap = up ? t + TAP_STEP : t - TAP_STEP;
    endfunction

    // ==========================================================
    // Leaf modules
    scan_chain_store chain_u (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .shift_enable_in(scan_enable_in),
        .shift_data_in(scan_data_in),
        .update_in(config_update_in),
        .applied_out(applied),
        .reconfig_done_out(reconfig_done_out)
    );

    assign ps.step_req = phase_step_in;
    assign ps.step_up = phase_up_in;
    assign ps.step_sel = phase_select_in;
    assign phase_done_out = ps.done;

    phase_step_engine engine_u (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ps(ps.engine)
    );

    // ==========================================================
    // Decoded counter settings
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            division_factor_out <= '0;
            counter_bypass_out <= '0;
            odd_duty_out <= '0;
            high_count_out <= '0;
        end else begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                division_factor_out[i] <= factor(segment(applied, i));
                counter_bypass_out[i] <= applied[i*SEG_LEN + SEG_BYPASS_POS];
                odd_duty_out[i] <= applied[i*SEG_LEN + SEG_ODD_POS]
                                   & ~applied[i*SEG_LEN + SEG_BYPASS_POS];
                high_count_out[i] <= applied[i*SEG_LEN + SEG_HIGH_POS +: COUNT_WIDTH];
            end
        end
    end

    // ==========================================================
    // Bandwidth settings
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pump_current_code_out <= '0;
            filter_resistor_code_out <= '0;
            filter_capacitor_code_out <= '0;
            settings_legal_out <= 1'b1;
        end else begin
            pump_current_code_out <= applied[PUMP_LSB +: PUMP_WIDTH];
            filter_resistor_code_out <= applied[RES_LSB +: RES_WIDTH];
            filter_capacitor_code_out <= applied[CAP_LSB +: CAP_WIDTH];
            settings_legal_out <= legal_pump(applied[PUMP_LSB +: PUMP_WIDTH])
                               && legal_res(applied[RES_LSB +: RES_WIDTH])
                               && legal_cap(applied[CAP_LSB +: CAP_WIDTH]);
        end
    end

    // ==========================================================
    // Phase taps, moved without the serial chain
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tap_reg <= {NUM_TAPS{TAP_RESET}};
        end else if (ps.start) begin
            for (int i = 0; i < NUM_TAPS; i++) begin
                if ((ps.start_sel == SEL_ALL_OUT && i >= TAP_OUT_FIRST)
                    || (ps.start_sel == SEL_FEEDBACK && i == TAP_FEEDBACK)
                    || (ps.start_sel >= SEL_OUT0 && ps.start_sel <= SEL_OUT4
                        && i == int'(ps.start_sel) - int'(SEL_OUT0) + TAP_OUT_FIRST)) begin
                    tap_reg[i] <= step_tap(tap_reg[i], ps.start_up);
                end
            end
        end
    end

    assign phase_tap_out = tap_reg;

    // Clocks are never gated by phase stepping
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            output_clocks_run_out <= 1'b1;
        end else begin
            output_clocks_run_out <= 1'b1;
        end
    end

    // ==========================================================
    // Assertions
    localparam int DONE_MIN = 1;
    localparam int DONE_MAX = 4;

    property p_start_delay;
        @(posedge clk_in) disable iff (rst_in)
        ($rose(phase_step_in) && phase_done_out && !ps.start) |-> ##3 ps.start;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("step start late");

    property p_done_low;
        @(posedge clk_in) disable iff (rst_in)
        ps.start |-> !phase_done_out && $past(phase_done_out);
    endproperty
    a_done_low: assert property (p_done_low) else $error("done not falling");

    property p_done_return;
        @(posedge clk_in) disable iff (rst_in)
        ps.start |-> ##[DONE_MIN:DONE_MAX] phase_done_out;
    endproperty
    a_done_return: assert property (p_done_return) else $error("done not back");

    property p_single_step;
        @(posedge clk_in) disable iff (rst_in)
        ps.start |=> !ps.start [*2];
    endproperty
    a_single_step: assert property (p_single_step) else $error("double step");

    property p_tap_up_fb;
        @(posedge clk_in) disable iff (rst_in)
        (ps.start && ps.start_up && ps.start_sel == SEL_FEEDBACK)
        |=> tap_reg[TAP_FEEDBACK] == $past(tap_reg[TAP_FEEDBACK]) + TAP_STEP
            && tap_reg[TAP_OUT_FIRST] == $past(tap_reg[TAP_OUT_FIRST]);
    endproperty
    a_tap_up_fb: assert property (p_tap_up_fb) else $error("feedback tap");

    property p_tap_down_out0;
        @(posedge clk_in) disable iff (rst_in)
        (ps.start && !ps.start_up && ps.start_sel == SEL_OUT0)
        |=> tap_reg[TAP_OUT_FIRST] == $past(tap_reg[TAP_OUT_FIRST]) - TAP_STEP;
    endproperty
    a_tap_down_out0: assert property (p_tap_down_out0) else $error("out0 tap");

    property p_select_all;
        @(posedge clk_in) disable iff (rst_in)
        (ps.start && ps.start_up && ps.start_sel == SEL_ALL_OUT)
        |=> tap_reg[NUM_TAPS-1] == $past(tap_reg[NUM_TAPS-1]) + TAP_STEP
            && tap_reg[TAP_FEEDBACK] == $past(tap_reg[TAP_FEEDBACK]);
    endproperty
    a_select_all: assert property (p_select_all) else $error("all select");

    property p_bypass_one;
        @(posedge clk_in) disable iff (rst_in)
        applied[SEG_FEEDBACK*SEG_LEN + SEG_BYPASS_POS]
        |=> division_factor_out[SEG_FEEDBACK] == FACTOR_ONE;
    endproperty
    a_bypass_one: assert property (p_bypass_one) else $error("bypass factor");

    property p_reconfig_flag;
        @(posedge clk_in) disable iff (rst_in)
        (config_update_in && !reconfig_done_out)
        |=> reconfig_done_out [*4] ##1 !reconfig_done_out;
    endproperty
    a_reconfig_flag: assert property (p_reconfig_flag) else $error("reconfig flag");

    property p_clocks_run;
        @(posedge clk_in) disable iff (rst_in)
        !phase_done_out |-> output_clocks_run_out;
    endproperty
    a_clocks_run: assert property (p_clocks_run) else $error("clocks stopped");

    property p_done_low_time;
        @(posedge clk_in) disable iff (rst_in)
        $fell(phase_done_out) |-> ##1 !phase_done_out ##1 phase_done_out;
    endproperty
    a_done_low_time: assert property (p_done_low_time) else $error("done low time");

    property p_no_restart;
        @(posedge clk_in) disable iff (rst_in)
        (!phase_done_out && !$fell(phase_done_out)) |-> !ps.start;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("start while busy");

    property p_tap_still;
        @(posedge clk_in) disable iff (rst_in)
        !ps.start |=> $stable(tap_reg);
    endproperty
    a_tap_still: assert property (p_tap_still) else $error("tap moved");

    property p_applied_hold;
        @(posedge clk_in) disable iff (rst_in)
        !$fell(reconfig_done_out) |-> $stable(applied);
    endproperty
    a_applied_hold: assert property (p_applied_hold) else $error("early apply");

    property p_odd_bypass;
        @(posedge clk_in) disable iff (rst_in)
        counter_bypass_out[SEG_FEEDBACK] |-> !odd_duty_out[SEG_FEEDBACK];
    endproperty
    a_odd_bypass: assert property (p_odd_bypass) else $error("odd bit not ignored");

    property p_start_capture;
        @(posedge clk_in) disable iff (rst_in)
        ps.start |-> ps.start_sel == $past(phase_select_in)
                     && ps.start_up == $past(phase_up_in);
    endproperty
    a_start_capture: assert property (p_start_capture) else $error("step not captured");

    c_step_up: cover property (@(posedge clk_in) disable iff (rst_in)
        ps.start && ps.start_up);
    c_step_all: cover property (@(posedge clk_in) disable iff (rst_in)
        ps.start && ps.start_sel == SEL_ALL_OUT);
    c_reconfig: cover property (@(posedge clk_in) disable iff (rst_in)
        $fell(reconfig_done_out));
    c_illegal: cover property (@(posedge clk_in) disable iff (rst_in)
        $fell(settings_legal_out));

endmodule
`default_nettype wire

//--- verilog/pll_reconfig_pkg.sv
// Constants and types for PLL reconfiguration and dynamic phase shifting
package pll_reconfig_pkg;

    // ==========================================================
    // Serial chain layout
    localparam int CHAIN_LEN = 144;
    localparam int SEG_LEN = 18;
    localparam int NUM_COUNTERS = 7;
    localparam int SEG_LOW_POS = 0;
    localparam int SEG_HIGH_POS = 8;
    localparam int SEG_ODD_POS = 16;
    localparam int SEG_BYPASS_POS = 17;
    localparam int COUNT_WIDTH = 8;
    localparam int FACTOR_WIDTH = 9;
    localparam int PUMP_LSB = 132;
    localparam int PUMP_WIDTH = 3;
    localparam int CAP_LSB = 137;
    localparam int CAP_WIDTH = 2;
    localparam int RES_LSB = 139;
    localparam int RES_WIDTH = 5;

    // Chain segment index: 0 holds the last output counter
    localparam int SEG_OUT4 = 0;
    localparam int SEG_OUT0 = 4;
    localparam int SEG_FEEDBACK = 5;
    localparam int SEG_PRESCALE = 6;

    // ==========================================================
    // Phase taps: index 0 feedback, 1..5 output counters zero..four
    localparam int NUM_TAPS = 6;
    localparam int TAP_FEEDBACK = 0;
    localparam int TAP_OUT_FIRST = 1;
    localparam int TAP_WIDTH = 3;
    localparam logic [TAP_WIDTH-1:0] TAP_RESET = 3'h0;
    localparam logic [TAP_WIDTH-1:0] TAP_STEP = 3'h1;
    localparam logic [FACTOR_WIDTH-1:0] FACTOR_ONE = 9'h001;

    // ==========================================================
    // Timing of the internal PLL answers, in scan clock cycles
    localparam int PHASE_BUSY_CYCLES = 2;
    localparam int RECONFIG_BUSY_CYCLES = 4;
    localparam int BUSY_CNT_WIDTH = 4;

    // ==========================================================
    // Counter select codes
    typedef enum logic [2:0] {
        SEL_ALL_OUT = 3'h0,
        SEL_FEEDBACK = 3'h1,
        SEL_OUT0 = 3'h2,
        SEL_OUT1 = 3'h3,
        SEL_OUT2 = 3'h4,
        SEL_OUT3 = 3'h5,
        SEL_OUT4 = 3'h6
    } counter_select_type;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_ARMED = 2'h1,
        PH_SHIFT = 2'h2
    } phase_state_type;

endpackage

//--- verilog/scan_chain_store.sv
// Serial reconfiguration chain with update and done flag
`timescale 1ns/1ps
`default_nettype none
module scan_chain_store
    import pll_reconfig_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Shift and update
    input wire logic shift_enable_in,
    input wire logic shift_data_in,
    input wire logic update_in,
    // Applied contents
    output logic [CHAIN_LEN-1:0] applied_out,
    output logic reconfig_done_out
);

    logic [CHAIN_LEN-1:0] shift_reg;
    logic [BUSY_CNT_WIDTH-1:0] busy_reg;

    // ==========================================================
    // Shift: first bit in lands at position zero after a full load
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            shift_reg <= '0;
        end else if (shift_enable_in) begin
            shift_reg <= {shift_data_in, shift_reg[CHAIN_LEN-1:1]};
        end
    end

    // ==========================================================
    // Apply with done flag
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            applied_out <= '0;
            reconfig_done_out <= 1'b0;
            busy_reg <= '0;
        end else if (reconfig_done_out) begin
            if (busy_reg == BUSY_CNT_WIDTH'(RECONFIG_BUSY_CYCLES - 1)) begin
                applied_out <= shift_reg;
                reconfig_done_out <= 1'b0;
            end else begin
                busy_reg <= busy_reg + 1'b1;
            end
        end else if (update_in) begin
            reconfig_done_out <= 1'b1;
            busy_reg <= '0;
        end
    end

endmodule
`default_nettype wire
